// File: core/sram_ctrl_map.svh
// constants for the pipelined burst sram: widths, reset values, codes
// assumes nothing; included by its bare name from the core files
`ifndef SRAM_CTRL_MAP_SVH
`define SRAM_CTRL_MAP_SVH

// array shape: 256k words of four nine-bit lanes
`define SRAM_ADDR_W 18
`define SRAM_LANES 4
`define SRAM_BYTE_W 9

// the burst counter steps the two low address bits
`define SRAM_BURST_W 2
`define SRAM_BURST_ZERO 2'h0
`define SRAM_BURST_ONE 2'h1

// reset values of control state
`define SRAM_BIT_CLEAR 1'h0
`define SRAM_BIT_SET 1'h1

`endif

// File: core/sram_ctrl_pkg.sv
// types shared by the burst sram control files
// assumes the constants header is on the include path
`default_nettype none
package sram_ctrl_pkg;

  // operation held in the command stage, one-hot
  typedef enum logic [2:0] {
    OP_NONE  = 3'b001,
    OP_READ  = 3'b010,
    OP_WRITE = 3'b100
  } op_t;

endpackage
`default_nettype wire

// File: core/burst_sequencer.sv
// burst address generator for the two low address bits
// assumes the caller holds the start value and the step count
`timescale 1ns/1ns
`default_nettype none
module burst_sequencer #(
  parameter int W = 2
) (
  input wire logic [W-1:0] start_in,
  input wire logic [W-1:0] count_in,
  input wire logic interleave_in,
  output logic [W-1:0] addr_out
);

  // linear wraps modulo four, interleaved flips bits of the start
  always_comb begin
    if (interleave_in) begin
      addr_out = start_in ^ count_in; // see R20
    end else begin
      addr_out = W'(start_in + count_in); // see R20
    end
  end

endmodule
`default_nettype wire

// File: core/sram_array.sv
// storage array with lane write enables and a registered read port
// assumes at most one read or one write per clock
`timescale 1ns/1ns
`default_nettype none
module sram_array #(
  parameter int ADDR_W = 18,
  parameter int LANES = 4,
  parameter int BYTE_W = 9
) (
  input wire logic sys_clk_in,
  input wire logic wr_en_in,
  input wire logic [LANES-1:0] wr_lanes_in,
  input wire logic rd_en_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [LANES*BYTE_W-1:0] wr_data_in,
  output logic [LANES*BYTE_W-1:0] rd_data_out
);

  logic [LANES*BYTE_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [LANES*BYTE_W-1:0] word_next;
  logic [LANES*BYTE_W-1:0] rd_next;

  // merge the enabled lanes into the stored word
  always_comb begin
    word_next = mem[addr_in];
    for (int i = 0; i < LANES; i++) begin
      if (wr_lanes_in[i]) begin
        word_next[i*BYTE_W +: BYTE_W] = wr_data_in[i*BYTE_W +: BYTE_W];
      end
    end
    rd_next = rd_en_in ? mem[addr_in] : rd_data_out;
  end

  // no reset on the array, so contents ride through reset and sleep
  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem[addr_in] <= word_next; // see R14
    end
    rd_data_out <= rd_next;
  end

endmodule
`default_nettype wire

// File: core/pipelined_burst_sram_control.sv
// control core of a pipelined synchronous burst static ram
// assumes a single system clock; pins are sampled on its rising edge
//
// What this block does
// R1: lanes drive only while output enable is low, released at once.
// R2: address, data and controls register on the clock edge.
// R3: burst order select low means linear, high means interleaved.
// R4: burst order select is held steady by the outside party.
// R5: low two address bits feed the burst counter.
// R6: four byte write selects, one per byte lane.
// R7: global write writes every lane regardless of other write inputs.
// R8: write qualifier writes only lanes whose byte selects are low.
// R9: byte-only systems tie global write high, qualifier low.
// R10: primary enable high blocks processor strobe; controller strobe deselects.
// R11: expansion enable high must be high for selection.
// R12: sleep request high stops the internal clock at once.
// R13: after sleep drops, stay asleep until a read or write command.
// R14: stored contents survive sleep.
// R15: test reset clears scan logic asynchronously.
// R16: controller strobe aborts a burst and loads a new address.
// R17: processor strobe aborts a burst unless primary enable is high.
// R18: burst advance steps the counter in the selected order.
// R19: expansion enable low must be low for selection.
// R20: linear adds modulo four, interleaved xors start with the count.
// R21: read data passes an output register before reaching the lanes.
`timescale 1ns/1ns
`default_nettype none
`include "sram_ctrl_map.svh"
module pipelined_burst_sram_control #(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int LANES = `SRAM_LANES,
  parameter int BYTE_W = `SRAM_BYTE_W
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] sync_address_in,
  input wire logic [LANES*BYTE_W-1:0] data_byte_lanes_in,
  output logic [LANES*BYTE_W-1:0] data_byte_lanes_out,
  output logic [LANES-1:0] data_byte_lanes_oe_out,
  input wire logic output_enable_n_in,
  input wire logic burst_order_select_in,
  input wire logic sleep_request_in,
  input wire logic controller_address_strobe_n_in,
  input wire logic processor_address_strobe_n_in,
  input wire logic burst_advance_n_in,
  input wire logic primary_chip_enable_n_in,
  input wire logic expansion_enable_high_in,
  input wire logic expansion_enable_low_n_in,
  input wire logic global_write_n_in,
  input wire logic write_qualifier_n_in,
  input wire logic [LANES-1:0] byte_write_select_n_in,
  input wire logic test_clk_in,
  input wire logic test_data_in,
  input wire logic test_reset_n_in,
  output logic scan_data_out,
  output logic low_power_out
);
  import sram_ctrl_pkg::*;

  localparam int BW = `SRAM_BURST_W;
  localparam int DW = LANES * BYTE_W;

  // command decode
  logic selected;
  logic processor_address_strobe_take;
  logic start_cmd;
  logic write_req;
  logic [LANES-1:0] lanes_req;
  logic wake;
  logic run;
  logic [BW-1:0] seq_start;
  logic [BW-1:0] seq_count;
  logic [BW-1:0] seq_addr;

  // burst and command state
  logic active_reg, active_next;
  logic [ADDR_W-1:0] base_reg, base_next;
  logic [BW-1:0] cnt_reg, cnt_next;
  op_t op_reg, op_next;
  logic [ADDR_W-1:0] cmd_addr_reg, cmd_addr_next;
  logic [DW-1:0] cmd_data_reg, cmd_data_next;
  logic [LANES-1:0] cmd_lanes_reg, cmd_lanes_next;
  logic asleep_reg, asleep_next;

  // read pipeline
  logic rd_valid_reg, rd_valid_next;
  logic drive_reg, drive_next;
  logic [DW-1:0] dout_reg, dout_next;
  logic [DW-1:0] mem_rd_data;

  // scan logic
  logic tck_meta_reg, tck_sync_reg, tck_prev_reg, bypass_reg;
  logic tck_meta_next, tck_sync_next, tck_prev_next, bypass_next;

  // selection and strobe qualification
  always_comb begin
    selected = !primary_chip_enable_n_in // see R10
      && expansion_enable_high_in // see R11
      && !expansion_enable_low_n_in; // see R19
    // processor strobe is blocked while the primary enable is high
    processor_address_strobe_take = !processor_address_strobe_n_in
      && !primary_chip_enable_n_in; // see R17
    start_cmd = processor_address_strobe_take || !controller_address_strobe_n_in; // see R16
  end

  // write lane selection; global write overrides everything else
  always_comb begin
    if (!global_write_n_in) begin
      lanes_req = {LANES{1'b1}}; // see R7
    end else if (!write_qualifier_n_in) begin
      lanes_req = ~byte_write_select_n_in; // see R6 see R8
    end else begin
      lanes_req = '0;
    end
    write_req = |lanes_req;
  end

  // sleep gates every burst and pipeline update combinationally, modelling a stopped clock; the sleep flag and scan logic still update
  always_comb begin
    wake = start_cmd && selected;
    run = !sleep_request_in && (!asleep_reg || wake); // see R12 see R13
    if (sleep_request_in) begin
      asleep_next = `SRAM_BIT_SET; // see R12
    end else if (wake) begin
      asleep_next = `SRAM_BIT_CLEAR; // see R13
    end else begin
      asleep_next = asleep_reg;
    end
  end

  // start bits come from the pins on a new address, else from the base
  always_comb begin
    seq_start = start_cmd ? sync_address_in[BW-1:0] : base_reg[BW-1:0]; // see R5
    seq_count = start_cmd ? `SRAM_BURST_ZERO : cnt_next;
  end

  // order select is used live, never registered
  burst_sequencer #(
    .W(BW)
  ) u_seq (
    .start_in(seq_start),
    .count_in(seq_count),
    .interleave_in(burst_order_select_in), // see R3 see R4
    .addr_out(seq_addr)
  );

  // burst control: new address, advance, suspend or deselect
  always_comb begin
    active_next = active_reg;
    base_next = base_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    cmd_addr_next = cmd_addr_reg;
    cmd_data_next = cmd_data_reg;
    cmd_lanes_next = cmd_lanes_reg;
    if (run) begin
      op_next = OP_NONE;
      cmd_data_next = data_byte_lanes_in; // see R2
      cmd_lanes_next = '0;
      if (start_cmd) begin
        // a strobe cuts any running burst short
        active_next = selected; // see R10 see R16 see R17
        base_next = sync_address_in; // see R2
        cnt_next = `SRAM_BURST_ZERO;
        if (selected) begin
          // processor strobe starts a read; writes follow on later cycles
          if (!processor_address_strobe_take && write_req) begin
            op_next = OP_WRITE;
            cmd_lanes_next = lanes_req;
          end else begin
            op_next = OP_READ;
          end
        end
      end else if (active_reg) begin
        if (!burst_advance_n_in) begin
          cnt_next = BW'(cnt_reg + `SRAM_BURST_ONE); // see R18
        end
        if (write_req) begin
          op_next = OP_WRITE;
          cmd_lanes_next = lanes_req;
        end else begin
          op_next = OP_READ;
        end
      end
      cmd_addr_next = {base_next[ADDR_W-1:BW], seq_addr}; // see R5 see R20
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      active_reg <= `SRAM_BIT_CLEAR;
      base_reg <= '0;
      cnt_reg <= `SRAM_BURST_ZERO;
      op_reg <= OP_NONE;
      cmd_addr_reg <= '0;
      cmd_data_reg <= '0;
      cmd_lanes_reg <= '0;
      asleep_reg <= `SRAM_BIT_CLEAR;
    end else begin
      active_reg <= active_next;
      base_reg <= base_next;
      cnt_reg <= cnt_next;
      op_reg <= op_next;
      cmd_addr_reg <= cmd_addr_next;
      cmd_data_reg <= cmd_data_next;
      cmd_lanes_reg <= cmd_lanes_next;
      asleep_reg <= asleep_next;
    end
  end

  // array acts on the command one edge after it was registered
  sram_array #(
    .ADDR_W(ADDR_W),
    .LANES(LANES),
    .BYTE_W(BYTE_W)
  ) u_array (
    .sys_clk_in(sys_clk_in),
    .wr_en_in(run && op_reg == OP_WRITE),
    .wr_lanes_in(cmd_lanes_reg),
    .rd_en_in(run && op_reg == OP_READ),
    .addr_in(cmd_addr_reg),
    .wr_data_in(cmd_data_reg),
    .rd_data_out(mem_rd_data)
  );

  // output register: read data waits one more edge before the lanes
  always_comb begin
    rd_valid_next = rd_valid_reg;
    drive_next = drive_reg;
    dout_next = dout_reg;
    if (run) begin
      rd_valid_next = (op_reg == OP_READ);
      drive_next = rd_valid_reg;
      if (rd_valid_reg) begin
        dout_next = mem_rd_data; // see R21
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_valid_reg <= `SRAM_BIT_CLEAR;
      drive_reg <= `SRAM_BIT_CLEAR;
      dout_reg <= '0;
    end else begin
      rd_valid_reg <= rd_valid_next;
      drive_reg <= drive_next;
      dout_reg <= dout_next;
    end
  end

  // pin enable must react without a clock, so it is the only gated output
  always_comb begin
    data_byte_lanes_out = dout_reg;
    data_byte_lanes_oe_out = {LANES{drive_reg && !output_enable_n_in}}; // see R1
    low_power_out = asleep_reg;
    scan_data_out = bypass_reg;
  end

  // test clock is oversampled; the second and third stages feed the edge test
  always_comb begin
    tck_meta_next = test_clk_in;
    tck_sync_next = tck_meta_reg;
    tck_prev_next = tck_sync_reg;
    bypass_next = bypass_reg;
    if (rst_in) begin
      bypass_next = `SRAM_BIT_CLEAR;
    end else if (tck_sync_reg && !tck_prev_reg) begin
      bypass_next = test_data_in;
    end
  end

  // test reset acts without any clock edge
  always_ff @(posedge sys_clk_in or negedge test_reset_n_in) begin
    if (!test_reset_n_in) begin
      tck_meta_reg <= `SRAM_BIT_CLEAR; // see R15
      tck_sync_reg <= `SRAM_BIT_CLEAR;
      tck_prev_reg <= `SRAM_BIT_CLEAR;
      bypass_reg <= `SRAM_BIT_CLEAR;
    end else begin
      tck_meta_reg <= tck_meta_next;
      tck_sync_reg <= tck_sync_next;
      tck_prev_reg <= tck_prev_next;
      bypass_reg <= bypass_next;
    end
  end

  // lanes never drive while the enable pin is high
  a_oe_gated: assert property ( // see R1
    @(posedge sys_clk_in) disable iff (rst_in)
    output_enable_n_in |-> data_byte_lanes_oe_out == '0)
    else $error("lanes driven while output enable high");

  // a read command reaches the lanes two edges later
  a_read_latency: assert property ( // see R21
    @(posedge sys_clk_in) disable iff (rst_in)
    (run && op_reg == OP_READ) ##1 run |=> drive_reg)
    else $error("read data not driven two edges after command");

  // global write selects all lanes
  a_global_all: assert property ( // see R7
    @(posedge sys_clk_in) disable iff (rst_in)
    (run && active_next && !global_write_n_in && !processor_address_strobe_take)
      |=> op_reg == OP_WRITE && cmd_lanes_reg == {LANES{1'b1}})
    else $error("global write missed a lane");

  // qualified writes follow the byte selects exactly
  a_byte_lanes: assert property ( // see R8
    @(posedge sys_clk_in) disable iff (rst_in)
    (run && global_write_n_in && !write_qualifier_n_in)
      |=> cmd_lanes_reg == ~$past(byte_write_select_n_in) || op_reg != OP_WRITE)
    else $error("written lanes differ from byte selects");

  // controller strobe with primary enable high deselects
  a_controller_address_strobe_deselect: assert property ( // see R10
    @(posedge sys_clk_in) disable iff (rst_in)
    (run && !controller_address_strobe_n_in && primary_chip_enable_n_in)
      |=> !active_reg && op_reg == OP_NONE)
    else $error("controller strobe did not deselect");

  // blocked processor strobe leaves an idle device idle
  a_processor_address_strobe_blocked: assert property ( // see R17
    @(posedge sys_clk_in) disable iff (rst_in)
    (!processor_address_strobe_n_in && primary_chip_enable_n_in
      && controller_address_strobe_n_in && !active_reg)
      |=> !active_reg)
    else $error("blocked processor strobe selected device");

  // linear order adds the count to the start bits
  a_linear_step: assert property ( // see R3
    @(posedge sys_clk_in) disable iff (rst_in)
    (run && active_reg && !start_cmd && !burst_order_select_in)
      |=> cmd_addr_reg[BW-1:0] == BW'(base_reg[BW-1:0] + cnt_reg))
    else $error("linear burst address wrong");

  // stopped clock freezes the command stage
  a_sleep_freeze: assert property ( // see R12
    @(posedge sys_clk_in) disable iff (rst_in)
    sleep_request_in |=> $stable(cmd_addr_reg) && $stable(dout_reg))
    else $error("state moved while asleep");

  // after sleep, only a selected command wakes the device
  a_wake_cmd: assert property ( // see R13
    @(posedge sys_clk_in) disable iff (rst_in)
    (asleep_reg && !sleep_request_in && !wake) |=> asleep_reg)
    else $error("woke without a command");

  // scan logic is clear while test reset is low
  a_test_reset: assert property ( // see R15
    @(posedge sys_clk_in)
    !test_reset_n_in |-> !scan_data_out)
    else $error("scan logic not reset");

endmodule
`default_nettype wire

// File: dv/cache_ctrl_model.sv
// cache controller model driving the burst sram command pins
// assumes the bench calls its tasks; pins change at the falling edge
`timescale 1ns/1ns
`default_nettype none
`include "sram_ctrl_map.svh"
module cache_ctrl_model (
  input wire logic sys_clk_in,
  output logic [`SRAM_ADDR_W-1:0] addr_out,
  output logic [`SRAM_LANES*`SRAM_BYTE_W-1:0] wdata_out,
  output logic ctl_strobe_n_out,
  output logic proc_strobe_n_out,
  output logic advance_n_out,
  output logic chip_en_n_out,
  output logic exp_hi_out,
  output logic exp_lo_n_out,
  output logic gwrite_n_out,
  output logic wqual_n_out,
  output logic [3:0] lane_sel_n_out,
  output logic oe_n_out,
  output logic order_out,
  output logic sleep_out
);
  // idle pins at time zero, chip selected, linear order
  initial begin
    {ctl_strobe_n_out, proc_strobe_n_out, advance_n_out} = 3'h7;
    {gwrite_n_out, wqual_n_out, lane_sel_n_out} = 6'h3f;
    addr_out = '0;
    wdata_out = '0;
    set_enables(1'b0, 1'b1, 1'b0);
    set_pins(1'b0, 1'b0, 1'b0);
  end

  // one command per falling edge; data not written is scrambled so
  // a stale value never passes for a real write
  task automatic step(input logic cs_n, ps_n, av_n, gw_n, wq_n,
                      input logic [3:0] ln_n,
                      input logic [`SRAM_ADDR_W-1:0] a,
                      input logic [`SRAM_LANES*`SRAM_BYTE_W-1:0] d);
    @(negedge sys_clk_in);
    ctl_strobe_n_out = cs_n;
    proc_strobe_n_out = ps_n;
    advance_n_out = av_n;
    gwrite_n_out = gw_n;
    wqual_n_out = wq_n;
    lane_sel_n_out = ln_n;
    addr_out = a;
    wdata_out = (gw_n & wq_n) ? ~wdata_out : d;
  endtask

  // nothing requested; address bus wanders
  task automatic idle();
    step(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, ~addr_out, wdata_out);
  endtask

  task automatic set_enables(input logic ce_n, hi, lo_n);
    chip_en_n_out = ce_n;
    exp_hi_out = hi;
    exp_lo_n_out = lo_n;
  endtask

  // order only changes between bursts, never inside one
  task automatic set_pins(input logic g_n, ord, slp);
    oe_n_out = g_n;
    order_out = ord;
    sleep_out = slp;
  endtask
endmodule
`default_nettype wire

// File: dv/pipelined_burst_sram_control_tb_top.sv
// self-checking bench for the pipelined burst sram control core
// assumes the core and the cache controller model are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "sram_ctrl_map.svh"
module pipelined_burst_sram_control_tb_top;
  localparam int AW = `SRAM_ADDR_W;
  localparam int DW = `SRAM_LANES * `SRAM_BYTE_W;
  localparam logic [AW-1:0] BASE = 18'h0_1230;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic tck = 1'b0, tdi = 1'b0, trst_n = 1'b1;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, dout;
  logic [3:0] ln_n, oe;
  logic cs_n, ps_n, av_n, ce_n, ehi, elo_n, gw_n, wq_n, g_n, ord, slp;
  logic scan, lp;
  int n_fail = 0, checked = 0, cyc = 0;

  always #10 sys_clk_in = ~sys_clk_in;

  cache_ctrl_model host (.sys_clk_in(sys_clk_in), .addr_out(addr),
    .wdata_out(wdata), .ctl_strobe_n_out(cs_n), .proc_strobe_n_out(ps_n),
    .advance_n_out(av_n), .chip_en_n_out(ce_n), .exp_hi_out(ehi),
    .exp_lo_n_out(elo_n), .gwrite_n_out(gw_n), .wqual_n_out(wq_n),
    .lane_sel_n_out(ln_n), .oe_n_out(g_n), .order_out(ord),
    .sleep_out(slp));

  pipelined_burst_sram_control dut (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .sync_address_in(addr), .data_byte_lanes_in(wdata),
    .data_byte_lanes_out(dout), .data_byte_lanes_oe_out(oe),
    .output_enable_n_in(g_n), .burst_order_select_in(ord),
    .sleep_request_in(slp), .controller_address_strobe_n_in(cs_n),
    .processor_address_strobe_n_in(ps_n), .burst_advance_n_in(av_n),
    .primary_chip_enable_n_in(ce_n), .expansion_enable_high_in(ehi),
    .expansion_enable_low_n_in(elo_n), .global_write_n_in(gw_n),
    .write_qualifier_n_in(wq_n), .byte_write_select_n_in(ln_n),
    .test_clk_in(tck), .test_data_in(tdi), .test_reset_n_in(trst_n),
    .scan_data_out(scan), .low_power_out(lp));

  // comparisons, one per kind of result
  task automatic chk_data(string nm, logic [DW-1:0] e, logic [DW-1:0] s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk_oe(string nm, logic [3:0] e, logic [3:0] s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk_bit(string nm, logic e, logic s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", nm, e, s);
    end
  endtask

  function automatic logic [DW-1:0] pat(input logic [1:0] k);
    return 36'h3_c3c3_c3c0 | {34'h0, k};
  endfunction

  // write through the controller strobe, chip selected
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d,
                    input logic g, q, input logic [3:0] l);
    host.step(1'b1 ^ 1'b1, 1'b1, 1'b1, g, q, l, a, d);
  endtask

  // processor strobe read; the word shows three falling edges later
  task automatic rd_check(input logic [AW-1:0] a, input logic [DW-1:0] e);
    host.step(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, a, '0);
    repeat (3) host.idle();
    chk_data("read word", e, dout);
    chk_oe("read drive", 4'hf, oe);
  endtask

  task automatic s_writes();
    wr(BASE, 36'h1_2345_6789, 1'b0, 1'b1, 4'hf);
    rd_check(BASE, 36'h1_2345_6789);
    // global write wins over a partial byte pattern
    wr(BASE, 36'h9_8765_4321, 1'b0, 1'b0, 4'he);
    rd_check(BASE, 36'h9_8765_4321);
    // lanes a and c only, byte-only style pins
    wr(BASE, 36'h0_0000_0000, 1'b1, 1'b0, 4'ha);
    rd_check(BASE, 36'h9_8001_4200);
    // controller strobe with no write request reads instead
    wr(BASE, 36'hf_ffff_ffff, 1'b1, 1'b1, 4'h0);
    rd_check(BASE, 36'h9_8001_4200);
  endtask

  // a stray processor strobe with chip disabled must not break the burst
  task automatic s_burst(input logic o, input logic [1:0] st);
    logic [1:0] idx;
    host.set_pins(1'b0, o, 1'b0);
    for (int i = 0; i < 7; i++) begin
      if (i == 0) host.step(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf,
                            BASE | {16'h0, st}, '0);
      else if (i < 4) host.step(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'hf,
                                BASE + 18'h40, '0);
      else host.idle();
      host.set_enables(i inside {[1:3]}, 1'b1, 1'b0);
      if (i >= 3) begin
        idx = o ? st ^ 2'(i - 3) : st + 2'(i - 3);
        chk_data("burst word", pat(idx), dout);
      end
    end
    host.set_pins(1'b0, 1'b0, 1'b0);
  endtask

  // controller strobe with one enable off deselects; drive drops
  task automatic s_deselect(input int v);
    host.step(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, BASE, '0);
    host.step(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, BASE, '0);
    host.set_enables(v == 0, v != 1, v == 2);
    // processor strobe goes out in the same instant the enables are restored, so the next edge sees it selected and it starts a new read at BASE
    host.step(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, BASE, '0);
    host.set_enables(1'b0, 1'b1, 1'b0);
    host.idle();
    chk_data("read before deselect", pat(0), dout);
    host.set_pins(1'b1, 1'b0, 1'b0);
    #1 chk_oe("drive with oe high", 4'h0, oe);
    host.idle();
    host.set_pins(1'b0, 1'b0, 1'b0);
    chk_oe("drive after deselect", 4'h0, oe);
  endtask

  task automatic s_sleep();
    wr(BASE + 18'h8, 36'h5_a5a5_a5a5, 1'b0, 1'b1, 4'hf);
    // two idles so the write reaches the array before the clock stops
    host.idle();
    host.idle();
    host.set_pins(1'b0, 1'b0, 1'b1);
    wr(BASE + 18'h8, 36'h0_f0f0_f0f0, 1'b0, 1'b1, 4'hf);
    host.idle();
    chk_bit("asleep", 1'b1, lp);
    host.set_pins(1'b0, 1'b0, 1'b0);
    host.step(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hf, BASE, '0);
    host.idle();
    chk_bit("still asleep", 1'b1, lp);
    rd_check(BASE + 18'h8, 36'h5_a5a5_a5a5);
    chk_bit("awake", 1'b0, lp);
  endtask

  // slow test clock shifts a one through, test reset clears it at once
  task automatic s_scan();
    tdi = 1'b1;
    repeat (2) begin
      repeat (4) @(negedge sys_clk_in);
      tck = 1'b1;
      repeat (4) @(negedge sys_clk_in);
      tck = 1'b0;
    end
    chk_bit("scan shifted", 1'b1, scan);
    trst_n = 1'b0;
    #1 chk_bit("scan reset", 1'b0, scan);
    @(negedge sys_clk_in);
    trst_n = 1'b1;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // cut a hang short well past the expected hundred or so cycles
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    repeat (16) @(negedge sys_clk_in);
    chk_oe("reset drive", 4'h0, oe);
    chk_data("reset data", '0, dout);
    chk_bit("reset sleep", 1'b0, lp);
    chk_bit("reset scan", 1'b0, scan);
    rst_in = 1'b0;
    s_writes();
    for (int k = 0; k < 4; k++)
      wr(BASE + AW'(k), pat(2'(k)), 1'b0, 1'b1, 4'hf);
    s_burst(1'b0, 2'h1);
    s_burst(1'b1, 2'h1);
    s_burst(1'b1, 2'h2);
    for (int v = 0; v < 3; v++)
      s_deselect(v);
    s_sleep();
    s_scan();
    complete_run();
  end
endmodule
`default_nettype wire
